//--- pkg/crj_regs.svh
`ifndef CRJ_REGS_SVH
`define CRJ_REGS_SVH
// ---------------------------------------------------------------
// opcodes and opcode nibbles
// ---------------------------------------------------------------
`define CRJ_OPC_INTERRUPT_RETURN_OP     8'hBF
`define CRJ_OPC_JP_PAIR  8'h30
`define CRJ_NIB_JP_CC    4'hD
`define CRJ_NIB_JR_CC    4'hB
`define CRJ_NIB_LD_IMM   4'hC
`define CRJ_NIB_LD_R2W   4'h8
`define CRJ_NIB_LD_W2R   4'h9
`define CRJ_OPC_LD_IRS   8'hC7
`define CRJ_OPC_LD_IRD   8'hD7
`define CRJ_OPC_LD_RR    8'hE4
`define CRJ_OPC_LD_RIR   8'hE5
`define CRJ_OPC_LD_RIM   8'hE6
`define CRJ_OPC_LD_IRIM  8'hD6
`define CRJ_OPC_LD_IRR   8'hF5
`define CRJ_OPC_LD_XS    8'h87
`define CRJ_OPC_LD_XD    8'h97
// ---------------------------------------------------------------
// flag register
// ---------------------------------------------------------------
`define CRJ_FLAGS_ADDR   8'hD5
`define CRJ_BIT_C        7
`define CRJ_BIT_Z        6
`define CRJ_BIT_S        5
`define CRJ_BIT_V        4
`define CRJ_BIT_FIS      1
// ---------------------------------------------------------------
// condition codes (low three bits; top bit inverts)
// ---------------------------------------------------------------
`define CRJ_CC_NEVER     3'h0
`define CRJ_CC_LT        3'h1
`define CRJ_CC_LE        3'h2
`define CRJ_CC_ULE       3'h3
`define CRJ_CC_OV        3'h4
`define CRJ_CC_MI        3'h5
`define CRJ_CC_EQ        3'h6
`define CRJ_CC_ULT       3'h7
`define CRJ_CC_INV_BIT   3
// ---------------------------------------------------------------
// lengths, stack steps, reset values
// ---------------------------------------------------------------
`define CRJ_LEN1         16'h0001
`define CRJ_LEN2         16'h0002
`define CRJ_LEN3         16'h0003
`define CRJ_SP_POP1      16'h0001
`define CRJ_SP_POP2      16'h0002
`define CRJ_PC_RST       16'h0000
`define CRJ_SP_RST       16'h0000
`define CRJ_FLAGS_RST    8'h00
`endif

//--- pkg/crj_pkg.sv
`default_nettype none
package crj_pkg;
  typedef enum logic [3:0] {
    CRJ_ST_IDLE = 4'h1,
    CRJ_ST_POPF = 4'h2,
    CRJ_ST_POPH = 4'h4,
    CRJ_ST_POPL = 4'h8
  } crj_state_t;

  typedef enum logic [2:0] {
    CRJ_OP_NONE = 3'h0,
    CRJ_OP_INTERRUPT_RETURN_OP = 3'h1,
    CRJ_OP_JPCC = 3'h2,
    CRJ_OP_JPRR = 3'h3,
    CRJ_OP_JR   = 3'h4,
    CRJ_OP_LD   = 3'h5
  } crj_op_t;
endpackage
`default_nettype wire

//--- design/crj_exec.sv
// Behaviour
// - normal return pops flags, then pc; sp steps
// - normal return sets global interrupt enable
// - normal return only when fast-return bit clear
// - fast return restores shadow flags, clears bit
// - fast return loads pc from instruction pointer, which gets pc+1
// - conditional absolute jump loads pc if true
// - unconditional jump loads pc from register pair
// - conditional jump three bytes, unconditional two
// - conditional jump byte: cc nibble, D nibble
// - relative jump adds displacement when true
// - displacement is signed byte, +127 to -128
// - displacement relative to next instruction address
// - relative jump two bytes: cc nibble, B nibble
// - load copies source to destination, source kept
// - jumps, and loads not aimed at the flags register, leave status flags unchanged
`include "crj_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module crj_exec
  import crj_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        exec_valid,
  input  wire logic [7:0]  exec_op0,
  input  wire logic [7:0]  exec_op1,
  input  wire logic [7:0]  exec_op2,
  input  wire logic [7:0]  ld_src_data,
  input  wire logic [7:0]  ld_dst_addr,
  input  wire logic [15:0] pair_data,
  input  wire logic        fast_entry,
  input  wire logic        gie_clear,
  input  wire logic [7:0]  stk_rdata,
  output logic             exec_ready,
  output logic             exec_done,
  output logic [15:0]      pc,
  output logic [15:0]      instruction_pointer,
  output logic [15:0]      sp,
  output logic [7:0]       flags,
  output logic [7:0]       flags_shadow,
  output logic             system_mode_gie,
  output logic             stk_rd,
  output logic [15:0]      stk_addr,
  output logic             rf_we,
  output logic [7:0]       rf_waddr,
  output logic [7:0]       rf_wdata
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic crj_op_t crj_decode(input logic [7:0] op);
    crj_op_t c;
    c = CRJ_OP_NONE;
    if (op == `CRJ_OPC_INTERRUPT_RETURN_OP) begin
      c = CRJ_OP_INTERRUPT_RETURN_OP;
    end else if (op == `CRJ_OPC_JP_PAIR) begin
      c = CRJ_OP_JPRR;
    end else if (op[3:0] == `CRJ_NIB_JP_CC) begin
      c = CRJ_OP_JPCC;
    end else if (op[3:0] == `CRJ_NIB_JR_CC) begin
      c = CRJ_OP_JR;
    end else if (op[3:0] == `CRJ_NIB_LD_IMM ||
                 op[3:0] == `CRJ_NIB_LD_R2W ||
                 op[3:0] == `CRJ_NIB_LD_W2R ||
                 op == `CRJ_OPC_LD_IRS || op == `CRJ_OPC_LD_IRD ||
                 op == `CRJ_OPC_LD_RR  || op == `CRJ_OPC_LD_RIR ||
                 op == `CRJ_OPC_LD_RIM || op == `CRJ_OPC_LD_IRIM ||
                 op == `CRJ_OPC_LD_IRR || op == `CRJ_OPC_LD_XS ||
                 op == `CRJ_OPC_LD_XD) begin
      c = CRJ_OP_LD;
    end
    return c;
  endfunction
  // two-byte load forms; every other load form is three bytes
  function automatic logic [15:0] crj_ld_len(input logic [7:0] op);
    logic two;
    two = op[3:0] == `CRJ_NIB_LD_IMM || op[3:0] == `CRJ_NIB_LD_R2W ||
          op[3:0] == `CRJ_NIB_LD_W2R || op == `CRJ_OPC_LD_IRS ||
          op == `CRJ_OPC_LD_IRD;
    return two ? `CRJ_LEN2 : `CRJ_LEN3;
  endfunction
  function automatic logic crj_cond(input logic [3:0] cc,
                                    input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic t;
    c = f[`CRJ_BIT_C];
    z = f[`CRJ_BIT_Z];
    s = f[`CRJ_BIT_S];
    v = f[`CRJ_BIT_V];
    unique case (cc[2:0])
      `CRJ_CC_NEVER: t = 1'b0;
      `CRJ_CC_LT:    t = s ^ v;
      `CRJ_CC_LE:    t = z | (s ^ v);
      `CRJ_CC_ULE:   t = c | z;
      `CRJ_CC_OV:    t = v;
      `CRJ_CC_MI:    t = s;
      `CRJ_CC_EQ:    t = z;
      `CRJ_CC_ULT:   t = c;
    endcase
    return t ^ cc[`CRJ_CC_INV_BIT];
  endfunction
  // ---------------------------------------------------------------
  // state and request acceptance
  // ---------------------------------------------------------------
  crj_state_t  state_reg;
  logic [15:0] pc_reg;
  logic [15:0] ip_reg;
  logic [15:0] sp_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  shadow_reg;
  logic        gie_reg;
  logic [7:0]  pch_reg;
  logic        stk_rd_reg;
  logic [15:0] stk_addr_reg;
  logic        done_reg;
  logic        rf_we_reg;
  logic [7:0]  rf_waddr_reg;
  logic [7:0]  rf_wdata_reg;
  crj_op_t     op_cls;
  logic        take;
  logic        fast_take;
  logic        is_fast_ret;
  logic        is_norm_ret;
  logic        cond_ok;
  logic        ld_flags;
  logic [15:0] pc_jr;

  assign fast_take   = fast_entry && state_reg == CRJ_ST_IDLE;
  assign exec_ready  = state_reg == CRJ_ST_IDLE && !fast_entry;
  assign take        = exec_valid && exec_ready;
  assign op_cls      = crj_decode(exec_op0);
  assign is_norm_ret = op_cls == CRJ_OP_INTERRUPT_RETURN_OP && !flags_reg[`CRJ_BIT_FIS];
  assign is_fast_ret = op_cls == CRJ_OP_INTERRUPT_RETURN_OP && flags_reg[`CRJ_BIT_FIS];
  assign cond_ok     = crj_cond(exec_op0[7:4], flags_reg);
  assign ld_flags    = op_cls == CRJ_OP_LD &&
                       ld_dst_addr == `CRJ_FLAGS_ADDR;
  // signed byte, added to the address after the two-byte jump
  assign pc_jr = pc_reg + `CRJ_LEN2 +
                 {{8{exec_op1[7]}}, exec_op1};
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= CRJ_ST_IDLE;
    end else begin
      unique case (state_reg)
        CRJ_ST_IDLE: begin
          if (take && is_norm_ret) begin
            state_reg <= CRJ_ST_POPF;
          end
        end
        CRJ_ST_POPF: state_reg <= CRJ_ST_POPH;
        CRJ_ST_POPH: state_reg <= CRJ_ST_POPL;
        CRJ_ST_POPL: state_reg <= CRJ_ST_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // stack reads: flags at sp, pc high at sp+1, pc low at sp+2
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      stk_rd_reg   <= 1'b0;
      stk_addr_reg <= `CRJ_SP_RST;
      pch_reg      <= `CRJ_FLAGS_RST;
    end else begin
      if (take && is_norm_ret) begin
        stk_rd_reg   <= 1'b1;
        stk_addr_reg <= sp_reg;
      end else if (state_reg == CRJ_ST_POPF ||
                   state_reg == CRJ_ST_POPH) begin
        stk_addr_reg <= sp_reg + `CRJ_SP_POP1;
      end else if (state_reg == CRJ_ST_POPL) begin
        stk_rd_reg <= 1'b0;
      end
      if (state_reg == CRJ_ST_POPH) begin
        pch_reg <= stk_rdata;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      sp_reg <= `CRJ_SP_RST;
    end else if (state_reg == CRJ_ST_POPF) begin
      sp_reg <= sp_reg + `CRJ_SP_POP1;
    end else if (state_reg == CRJ_ST_POPL) begin
      sp_reg <= sp_reg + `CRJ_SP_POP2;
    end
  end
  // ---------------------------------------------------------------
  // program counter and instruction pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_reg <= `CRJ_PC_RST;
      ip_reg <= `CRJ_PC_RST;
    end else if (fast_take) begin
      pc_reg <= ip_reg;
      ip_reg <= pc_reg;
    end else if (take) begin
      unique case (op_cls)
        CRJ_OP_INTERRUPT_RETURN_OP: begin
          if (is_fast_ret) begin
            pc_reg <= ip_reg;
            ip_reg <= pc_reg + `CRJ_LEN1;
          end
        end
        CRJ_OP_JPCC: begin
          pc_reg <= cond_ok ? {exec_op1, exec_op2}
                            : pc_reg + `CRJ_LEN3;
        end
        CRJ_OP_JPRR: pc_reg <= pair_data;
        CRJ_OP_JR: begin
          pc_reg <= cond_ok ? pc_jr : pc_reg + `CRJ_LEN2;
        end
        CRJ_OP_LD:   pc_reg <= pc_reg + crj_ld_len(exec_op0);
        CRJ_OP_NONE: pc_reg <= pc_reg + `CRJ_LEN1;
      endcase
    end else if (state_reg == CRJ_ST_POPL) begin
      pc_reg <= {pch_reg, stk_rdata};
    end
  end
  // ---------------------------------------------------------------
  // flags, shadow flags, global interrupt enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg  <= `CRJ_FLAGS_RST;
      shadow_reg <= `CRJ_FLAGS_RST;
    end else if (fast_take) begin
      shadow_reg             <= flags_reg;
      flags_reg[`CRJ_BIT_FIS] <= 1'b1;
    end else if (take && is_fast_ret) begin
      flags_reg              <= shadow_reg;
      flags_reg[`CRJ_BIT_FIS] <= 1'b0;
    end else if (take && ld_flags) begin
      flags_reg <= ld_src_data;
    end else if (state_reg == CRJ_ST_POPF) begin
      flags_reg <= stk_rdata;
    end
  end
  // the return's set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      gie_reg <= 1'b0;
    end else if (state_reg == CRJ_ST_POPL) begin
      gie_reg <= 1'b1;
    end else if (gie_clear) begin
      gie_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // register load write port and completion
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rf_we_reg    <= 1'b0;
      rf_waddr_reg <= `CRJ_FLAGS_RST;
      rf_wdata_reg <= `CRJ_FLAGS_RST;
    end else begin
      rf_we_reg <= take && op_cls == CRJ_OP_LD && !ld_flags;
      if (take && op_cls == CRJ_OP_LD) begin
        rf_waddr_reg <= ld_dst_addr;
        rf_wdata_reg <= ld_src_data;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (take && !is_norm_ret) || state_reg == CRJ_ST_POPL;
    end
  end
  assign exec_done           = done_reg;
  assign pc                  = pc_reg;
  assign instruction_pointer = ip_reg;
  assign sp                  = sp_reg;
  assign flags               = flags_reg;
  assign flags_shadow        = shadow_reg;
  assign system_mode_gie     = gie_reg;
  assign stk_rd              = stk_rd_reg;
  assign stk_addr            = stk_addr_reg;
  assign rf_we               = rf_we_reg;
  assign rf_waddr            = rf_waddr_reg;
  assign rf_wdata            = rf_wdata_reg;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_interrupt_return_op_sp_step: assert property (take && is_norm_ret |->
    ##4 sp_reg == $past(sp_reg, 4) + `CRJ_SP_POP1 + `CRJ_SP_POP2)
    else $error("stack pointer not advanced by three");
  a_interrupt_return_op_gie_set: assert property (take && is_norm_ret |->
    ##4 gie_reg && done_reg)
    else $error("normal return left interrupts off");
  a_interrupt_return_op_form_sel: assert property (take &&
    op_cls == CRJ_OP_INTERRUPT_RETURN_OP |=>
    (state_reg == CRJ_ST_POPF) == !$past(flags_reg[`CRJ_BIT_FIS]))
    else $error("wrong return form chosen");
  a_fast_flags: assert property (take && is_fast_ret |=>
    !flags_reg[`CRJ_BIT_FIS] &&
    flags_reg[`CRJ_BIT_C:`CRJ_BIT_V] ==
    $past(shadow_reg[`CRJ_BIT_C:`CRJ_BIT_V]))
    else $error("fast return flags not restored");
  a_fast_swap: assert property (take && is_fast_ret |=>
    pc_reg == $past(ip_reg) && ip_reg == $past(pc_reg) + `CRJ_LEN1)
    else $error("fast return did not swap pointers");
  a_jp_cond: assert property (take && op_cls == CRJ_OP_JPCC |=>
    pc_reg == ($past(cond_ok) ? {$past(exec_op1), $past(exec_op2)}
                              : $past(pc_reg) + `CRJ_LEN3))
    else $error("conditional jump target wrong");
  a_jp_pair: assert property (take && op_cls == CRJ_OP_JPRR |=>
    pc_reg == $past(pair_data))
    else $error("pair jump target wrong");
  a_jr_target: assert property (
    take && op_cls == CRJ_OP_JR |=> pc_reg == $past(pc_reg) + `CRJ_LEN2 +
    ($past(cond_ok) ? {{8{$past(exec_op1[7])}}, $past(exec_op1)} : 16'h0000))
    else $error("relative jump target wrong");
  a_ld_copy: assert property (take && op_cls == CRJ_OP_LD &&
    !ld_flags |=> rf_we && rf_wdata == $past(ld_src_data) &&
    rf_waddr == $past(ld_dst_addr))
    else $error("load write wrong");
  a_flags_kept: assert property (take && !ld_flags &&
    op_cls inside {CRJ_OP_JPCC, CRJ_OP_JPRR, CRJ_OP_JR, CRJ_OP_LD}
    |=> $stable(flags_reg))
    else $error("jump or load changed flags");
  c_norm_ret: cover property (take && is_norm_ret ##4 done_reg);
  c_fast_ret: cover property (fast_take ##[1:20] take && is_fast_ret);
  c_jr_taken: cover property (take && op_cls == CRJ_OP_JR && cond_ok);
endmodule // crj_exec
`default_nettype wire

//--- tb/crj_exec_tb.sv
`include "crj_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module crj_exec_tb;
  import crj_pkg::*;
  logic        clk, srst, exec_valid, fast_entry, gie_clear;
  logic [7:0]  op0, op1, op2, src_d, dst_a, stk_rdata;
  logic [15:0] pair_d, pc, ip, sp, stk_addr;
  logic        exec_ready, exec_done, gie, stk_rd, rf_we;
  logic [7:0]  flags, shadow, rf_waddr, rf_wdata;
  logic [7:0]  mem [0:255];
  logic [15:0] e_pc, e_ip, e_sp;
  logic [7:0]  e_fl, e_sh;
  logic        e_gie;
  int          n_mismatch, n_tests;
  logic [7:0]  ld_tab [12] = '{8'h0C, 8'h08, 8'h09, 8'hC7, 8'hD7, 8'hE4,
                               8'hE5, 8'hE6, 8'hD6, 8'hF5, 8'h87, 8'h97};

  crj_exec i_dut (.clk(clk), .srst(srst), .exec_valid(exec_valid),
    .exec_op0(op0), .exec_op1(op1), .exec_op2(op2), .ld_src_data(src_d),
    .ld_dst_addr(dst_a), .pair_data(pair_d), .fast_entry(fast_entry),
    .gie_clear(gie_clear), .stk_rdata(stk_rdata), .exec_ready(exec_ready),
    .exec_done(exec_done), .pc(pc), .instruction_pointer(ip), .sp(sp),
    .flags(flags), .flags_shadow(shadow), .system_mode_gie(gie),
    .stk_rd(stk_rd), .stk_addr(stk_addr), .rf_we(rf_we),
    .rf_waddr(rf_waddr), .rf_wdata(rf_wdata));

  // stack memory answers in the same cycle; idle bus shows inverted data
  assign stk_rdata = stk_rd ? mem[stk_addr[7:0]] : ~mem[stk_addr[7:0]];

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_state();
    chk("pc", e_pc, pc);
    chk("ip", e_ip, ip);
    chk("sp", e_sp, sp);
    chk("flags", {8'h00, e_fl}, {8'h00, flags});
    chk("gie", {15'h0, e_gie}, {15'h0, gie});
  endtask

  function automatic logic cc_true(input logic [3:0] c, input logic [7:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[5] ^ f[4];
      3'h2: r = f[6] | (f[5] ^ f[4]);
      3'h3: r = f[7] | f[6];
      3'h4: r = f[4];
      3'h5: r = f[5];
      3'h6: r = f[6];
      default: r = f[7];
    endcase
    return r ^ c[3];
  endfunction

  // ---------------------------------------------------------------
  // instruction drivers
  // ---------------------------------------------------------------
  task automatic issue(input logic [7:0] a, b, c, output int k,
                       output logic r1);
    op0 = a;
    op1 = b;
    op2 = c;
    exec_valid = 1'b1;
    @(posedge clk);
    #1;
    exec_valid = 1'b0;
    r1 = exec_ready;
    k = 0;
    while (exec_done !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 8) begin
      n_mismatch++;
      $display("CHECK FAILED done expected 1 seen 0");
      stop_test();
    end
  endtask

  task automatic do_jp(input logic [3:0] c, input logic [7:0] hi, lo);
    int k;
    logic r1;
    issue({c, `CRJ_NIB_JP_CC}, hi, lo, k, r1);
    e_pc = cc_true(c, e_fl) ? {hi, lo} : e_pc + 16'h0003;
    chk_state();
  endtask

  task automatic do_jr(input logic [3:0] c, input logic [7:0] d);
    int k;
    logic r1;
    issue({c, `CRJ_NIB_JR_CC}, d, 8'h00, k, r1);
    e_pc = e_pc + 16'h0002 + (cc_true(c, e_fl) ? {{8{d[7]}}, d} : 16'h0);
    chk_state();
  endtask

  task automatic do_jpp(input logic [15:0] v);
    int k;
    logic r1;
    pair_d = v;
    issue(`CRJ_OPC_JP_PAIR, 8'($urandom), 8'h00, k, r1);
    e_pc = v;
    chk_state();
  endtask

  task automatic do_ld(input int i, input logic [7:0] dst, src);
    int k;
    logic r1;
    logic [7:0] o;
    o = (i < 3) ? {4'($urandom), ld_tab[i][3:0]} : ld_tab[i];
    dst_a = dst;
    src_d = src;
    issue(o, 8'($urandom), 8'($urandom), k, r1);
    e_pc = e_pc + ((i < 5) ? 16'h0002 : 16'h0003);
    if (dst == `CRJ_FLAGS_ADDR) begin
      e_fl = src;
      chk("rf_we", 16'h0, {15'h0, rf_we});
    end else begin
      chk("rf_we", 16'h1, {15'h0, rf_we});
      chk("rf_waddr", {8'h0, dst}, {8'h0, rf_waddr});
      chk("rf_wdata", {8'h0, src}, {8'h0, rf_wdata});
    end
    chk_state();
  endtask

  task automatic do_fast_entry();
    logic [15:0] t;
    fast_entry = 1'b1;
    #1;
    chk("ready_fast", 16'h0, {15'h0, exec_ready});
    @(posedge clk);
    #1;
    fast_entry = 1'b0;
    t = e_pc;
    e_pc = e_ip;
    e_ip = t;
    e_sh = e_fl;
    e_fl[`CRJ_BIT_FIS] = 1'b1;
    chk_state();
    chk("shadow", {8'h0, e_sh}, {8'h0, shadow});
  endtask

  task automatic do_interrupt_return_op();
    int k;
    logic r1;
    logic [7:0] s;
    logic [15:0] t;
    s = e_sp[7:0];
    issue(`CRJ_OPC_INTERRUPT_RETURN_OP, 8'h00, 8'h00, k, r1);
    if (e_fl[`CRJ_BIT_FIS]) begin
      t = e_pc + 16'h0001;
      e_pc = e_ip;
      e_ip = t;
      e_fl = e_sh & 8'hFD;
      chk("fast_len", 16'h0, k[15:0]);
    end else begin
      e_fl = mem[s];
      e_pc = {mem[s + 8'h01], mem[s + 8'h02]};
      chk("stk_addr", e_sp + 16'h0002, stk_addr);
      chk("stk_rd", 16'h0, {15'h0, stk_rd});
      e_sp = e_sp + 16'h0003;
      e_gie = 1'b1;
      chk("pop_len", 16'h3, k[15:0]);
      chk("ready_pop", 16'h0, {15'h0, r1});
    end
    chk_state();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int r;
    int k;
    logic r1;
    clk = 1'b0;
    srst = 1'b1;
    {exec_valid, fast_entry, gie_clear} = 3'h0;
    {op0, op1, op2, src_d, dst_a} = 40'h0;
    pair_d = 16'h0000;
    n_mismatch = 0;
    n_tests = 0;
    {e_pc, e_ip, e_sp, e_fl, e_sh, e_gie} = 65'h0;
    void'($urandom(32'h040E));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    chk_state();
    chk("ready", 16'h1, {15'h0, exec_ready});
    @(posedge clk);
    #1;
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      do_ld(0, `CRJ_FLAGS_ADDR, 8'($urandom) & 8'hF0);
      do_jp(4'(c), 8'($urandom), 8'($urandom));
      do_jr(4'(c), 8'($urandom));
    end
    do_jr(4'h8, 8'h7F);
    do_jr(4'h8, 8'h80);
    do_jr(4'h0, 8'h80);
    do_jpp(16'hFFFF);
    issue(8'h00, 8'h00, 8'h00, k, r1);
    e_pc = e_pc + 16'h0001;
    chk_state();
    $display("test jumps done");
    mem[0] = mem[0] & 8'hFD;
    do_ld(1, `CRJ_FLAGS_ADDR, 8'($urandom) & 8'hFD);
    do_interrupt_return_op();
    do_interrupt_return_op();
    gie_clear = 1'b1;
    @(posedge clk);
    #1;
    gie_clear = 1'b0;
    e_gie = 1'b0;
    chk_state();
    do_fast_entry();
    do_interrupt_return_op();
    $display("test return done");
    for (int n = 0; n < 80; n++) begin
      r = $urandom % 6;
      case (r)
        0: do_jp(4'($urandom), 8'($urandom), 8'($urandom));
        1: do_jr(4'($urandom), 8'($urandom));
        2: do_jpp(16'($urandom));
        3: do_ld($urandom % 12, ($urandom % 4 == 0) ? 8'hD5 : 8'($urandom),
                 8'($urandom));
        4: do_fast_entry();
        default: do_interrupt_return_op();
      endcase
    end
    $display("test random done");
    stop_test();
  end
endmodule // crj_exec_tb
`default_nettype wire
